// >>> pkg/urp_pkg.sv
// Constants and types for the serial receiver with parity
package urp_pkg;
  // Register offsets
  localparam logic [2:0] ADR_STATUS = 3'h0;
  localparam logic [2:0] ADR_CONTROL = 3'h1;
  localparam logic [2:0] ADR_FORMAT = 3'h2;
  localparam logic [2:0] ADR_BAUD_LO = 3'h3;
  localparam logic [2:0] ADR_BAUD_HI = 3'h4;
  localparam logic [2:0] ADR_DATA = 3'h5;
  // status_reg_a fields
  localparam int ST_RXC = 7;
  localparam int ST_TXE = 5;
  localparam int ST_FE = 4;
  localparam int ST_DOR = 3;
  localparam int ST_UPE = 2;
  localparam int ST_U2X = 1;
  // control_reg_b fields
  localparam int CB_RXCIE = 7;
  localparam int CB_RXEN = 4;
  localparam int CB_TX_ENABLE_BIT = 3;
  localparam int CB_SIZE2 = 2;
  localparam int CB_RX9 = 1;
  localparam int CB_TX9 = 0;
  // format_reg_c fields
  localparam int FC_SYNC = 6;
  localparam int FC_PON = 5;
  localparam int FC_PODD = 4;
  localparam int FC_USBS = 3;
  localparam int FC_SIZE_LO = 1;
  // Reset values and codes
  localparam logic [2:0] SIZE_RST = 3'h3;
  localparam logic [2:0] SIZE_NINE = 3'h7;
  localparam logic [11:0] BAUD_RST = 12'h000;
  // Oversampling figures: normal, double speed
  localparam logic [4:0] OS_NORM = 5'h10;
  localparam logic [4:0] OS_DBL = 5'h08;
  localparam logic [4:0] VOTE_NORM = 5'h08;
  localparam logic [4:0] VOTE_DBL = 5'h04;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } urp_rx_t;

  // One receive buffer entry
  typedef struct packed {
    logic nine;
    logic fe;
    logic dor;
    logic upe;
    logic [7:0] data;
  } urp_entry_t;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } urp_bus_t;
endpackage : urp_pkg

// >>> verilog/urp_usart_rx.sv
// Serial receiver with two-entry buffer, parity and transmit framing
//
// Overview of operation
// - Parity bit sent between data and stop
// - Tx disable waits for shifter and buffer
// - Disabled transmitter releases serial output pin
// - Rx enable takes over serial input pin
// - Sync mode samples on transfer clock pin
// - Valid start bit begins frame shifting
// - Only first stop bit is examined
// - Stop bit moves frame into buffer
// - Unused upper data bits read zero
// - Ninth bit, flags stored per entry
// - Complete flag set while buffer nonempty
// - Rx disable flushes the buffer
// - Interrupt follows complete flag when enabled
// - Error flags travel with their character
// - Error flags ignore writes, no interrupts
// - Frame error is inverted first stop
// - Overrun on full buffer, waiting frame plus new start
// - Parity error reads zero when disabled
// - Checker compares computed and received parity
// - Parity error stored only if enabled
// - Rx disable abandons current frame at once
// - Disabled receiver releases serial input pin
// - Sixteen or eight samples per bit
// - Start accepted by majority of middle samples
// - Each bit by three-sample majority vote
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module urp_usart_rx #(
  parameter int BAUD_W = 12
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Register port
  input wire urp_pkg::urp_bus_t i_bus,
  output logic [7:0] o_rdata,
  // Serial pins
  input wire logic i_serial_in_pin,
  input wire logic i_transfer_clock_pin,
  output logic o_serial_out_pin,
  output logic o_serial_out_pin_oe,
  output logic o_serial_in_take,
  // Receive complete interrupt
  output logic o_rx_complete_irq
);
  // Rate fields below are fixed at twelve bits
  if (BAUD_W != 12)
  begin : g_baud_w_check
    $error("BAUD_W must be 12");
  end

  typedef struct packed {
    logic [11:0] baud;
    logic [11:0] bcnt;
    logic u2x;
    logic rxcie;
    logic rxen;
    logic tx_enable_bit;
    logic [2:0] size;
    logic tx9;
    logic sync;
    logic pon;
    logic podd;
    logic usbs;
    logic xck_prev;
    logic rx_prev;
    urp_pkg::urp_rx_t rst;
    logic [4:0] rsamp;
    logic [2:0] votes;
    logic [3:0] rbits;
    logic [8:0] rsh;
    logic rpar;
    logic pend_v;
    urp_pkg::urp_entry_t pend;
    logic dor_pend;
    urp_pkg::urp_entry_t [1:0] buff;
    logic rd_ptr;
    logic [1:0] cnt;
    logic tbuf_v;
    logic [8:0] tbuf;
    logic tbusy;
    logic [12:0] tsh;
    logic [3:0] tleft;
    logic [4:0] tsamp;
    logic txd;
    logic toe;
    logic [7:0] rdata;
    logic irq;
    logic take;
  } urp_state_t;

  urp_state_t s_q;
  urp_state_t s_d;

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : maj3

  function automatic logic [3:0] nbits(input logic [2:0] sz);
    nbits = (sz == urp_pkg::SIZE_NINE) ? 4'h9 : (4'h5 + {2'h0, sz[1:0]});
  endfunction : nbits

  // Even parity is XOR of the used bits, odd its inverse
  function automatic logic par(input logic [8:0] d, input logic odd);
    par = (^d) ^ odd;
  endfunction : par

  // Transmit frame, LSB first: start, data, optional parity, stops
  function automatic logic [12:0] txframe(input logic [8:0] d, input logic [3:0] n,
                                          input logic pon, input logic odd);
    logic [12:0] f;
    logic [8:0] m;
    f = 13'h1FFF;
    f[0] = 1'b0;
    m = d & ~(9'h1FF << n);
    for (int i = 0; i < 9; i++)
    begin
      if (i < n)
      begin
        f[1 + i] = m[i];
      end
    end
    if (pon)
    begin
      f[4'h1 + n] = par(m, odd);
    end
    txframe = f;
  endfunction : txframe

  logic tick;
  logic xck_rise;
  logic xck_fall;
  logic dec;
  logic adv;
  logic bitv;
  logic [4:0] ns;
  logic [4:0] os_n;
  logic [4:0] vote_f;
  logic [3:0] n;
  logic [8:0] rdat;
  logic [1:0] c;
  logic p;
  logic tbit;
  urp_pkg::urp_entry_t head;
  urp_pkg::urp_entry_t e;

  always_comb
  begin
    s_d = s_q;
    tick = (s_q.bcnt == 12'h000);
    xck_rise = ~s_q.xck_prev & i_transfer_clock_pin;
    xck_fall = s_q.xck_prev & ~i_transfer_clock_pin;
    os_n = s_q.u2x ? urp_pkg::OS_DBL : urp_pkg::OS_NORM;
    vote_f = s_q.u2x ? urp_pkg::VOTE_DBL : urp_pkg::VOTE_NORM;
    n = nbits(s_q.size);
    head = s_q.buff[s_q.rd_ptr];
    c = s_q.cnt;
    p = s_q.rd_ptr;
    e = '0;
    rdat = '0;
    ns = s_q.rsamp + 5'h01;
    dec = 1'b0;
    adv = 1'b0;
    bitv = 1'b0;
    tbit = 1'b0;
    s_d.bcnt = tick ? s_q.baud : (s_q.bcnt - 12'h001);
    s_d.xck_prev = i_transfer_clock_pin;
    s_d.rdata = 8'h00;

    // Register port
    if (i_bus.wr)
    begin
      if (i_bus.addr == urp_pkg::ADR_STATUS)
      begin
        s_d.u2x = i_bus.wdata[urp_pkg::ST_U2X];
      end
      else if (i_bus.addr == urp_pkg::ADR_CONTROL)
      begin
        s_d.rxcie = i_bus.wdata[urp_pkg::CB_RXCIE];
        s_d.rxen = i_bus.wdata[urp_pkg::CB_RXEN];
        s_d.tx_enable_bit = i_bus.wdata[urp_pkg::CB_TX_ENABLE_BIT];
        s_d.size[2] = i_bus.wdata[urp_pkg::CB_SIZE2];
        s_d.tx9 = i_bus.wdata[urp_pkg::CB_TX9];
      end
      else if (i_bus.addr == urp_pkg::ADR_FORMAT)
      begin
        s_d.sync = i_bus.wdata[urp_pkg::FC_SYNC];
        s_d.pon = i_bus.wdata[urp_pkg::FC_PON];
        s_d.podd = i_bus.wdata[urp_pkg::FC_PODD];
        s_d.usbs = i_bus.wdata[urp_pkg::FC_USBS];
        s_d.size[1:0] = i_bus.wdata[urp_pkg::FC_SIZE_LO +: 2];
      end
      else if (i_bus.addr == urp_pkg::ADR_BAUD_LO)
      begin
        s_d.baud[7:0] = i_bus.wdata;
      end
      else if (i_bus.addr == urp_pkg::ADR_BAUD_HI)
      begin
        s_d.baud[11:8] = i_bus.wdata[3:0];
      end
      else if (i_bus.addr == urp_pkg::ADR_DATA)
      begin
        if (s_q.tx_enable_bit && !s_q.tbuf_v)
        begin
          s_d.tbuf = {s_q.tx9, i_bus.wdata};
          s_d.tbuf_v = 1'b1;
        end
      end
    end
    if (i_bus.rd)
    begin
      if (i_bus.addr == urp_pkg::ADR_STATUS)
      begin
        s_d.rdata[urp_pkg::ST_RXC] = (s_q.cnt != 2'h0);
        s_d.rdata[urp_pkg::ST_TXE] = ~s_q.tbuf_v;
        s_d.rdata[urp_pkg::ST_FE] = (s_q.cnt != 2'h0) & head.fe;
        s_d.rdata[urp_pkg::ST_DOR] = (s_q.cnt != 2'h0) & head.dor;
        s_d.rdata[urp_pkg::ST_UPE] = (s_q.cnt != 2'h0) & head.upe & s_q.pon;
        s_d.rdata[urp_pkg::ST_U2X] = s_q.u2x;
      end
      else if (i_bus.addr == urp_pkg::ADR_CONTROL)
      begin
        s_d.rdata[urp_pkg::CB_RXCIE] = s_q.rxcie;
        s_d.rdata[urp_pkg::CB_RXEN] = s_q.rxen;
        s_d.rdata[urp_pkg::CB_TX_ENABLE_BIT] = s_q.tx_enable_bit;
        s_d.rdata[urp_pkg::CB_SIZE2] = s_q.size[2];
        s_d.rdata[urp_pkg::CB_RX9] = (s_q.cnt != 2'h0) & head.nine;
        s_d.rdata[urp_pkg::CB_TX9] = s_q.tx9;
      end
      else if (i_bus.addr == urp_pkg::ADR_FORMAT)
      begin
        s_d.rdata[urp_pkg::FC_SYNC] = s_q.sync;
        s_d.rdata[urp_pkg::FC_PON] = s_q.pon;
        s_d.rdata[urp_pkg::FC_PODD] = s_q.podd;
        s_d.rdata[urp_pkg::FC_USBS] = s_q.usbs;
        s_d.rdata[urp_pkg::FC_SIZE_LO +: 2] = s_q.size[1:0];
      end
      else if (i_bus.addr == urp_pkg::ADR_BAUD_LO)
      begin
        s_d.rdata = s_q.baud[7:0];
      end
      else if (i_bus.addr == urp_pkg::ADR_BAUD_HI)
      begin
        s_d.rdata = {4'h0, s_q.baud[11:8]};
      end
      else if (i_bus.addr == urp_pkg::ADR_DATA)
      begin
        // A data read advances the buffer; read status first
        if (s_q.cnt != 2'h0)
        begin
          s_d.rdata = head.data;
          p = ~s_q.rd_ptr;
          c = s_q.cnt - 2'h1;
        end
      end
    end

    // Receive sampling: baud tick oversampling or transfer clock edges
    if (s_q.sync)
    begin
      dec = xck_rise;
      adv = xck_rise;
      bitv = i_serial_in_pin;
    end
    else if (tick)
    begin
      s_d.rx_prev = i_serial_in_pin;
      s_d.rsamp = ns;
      if (ns >= vote_f && ns <= vote_f + 5'h02)
      begin
        s_d.votes = {s_q.votes[1:0], i_serial_in_pin};
      end
      dec = (ns == vote_f + 5'h02);
      adv = (ns == os_n);
      bitv = maj3({s_q.votes[1:0], i_serial_in_pin});
      if (adv)
      begin
        s_d.rsamp = 5'h00;
      end
    end

    // A waiting frame enters the buffer as soon as room opens
    if (s_q.pend_v && c != 2'h2)
    begin
      s_d.buff[p + c[0]] = s_q.pend;
      s_d.buff[p + c[0]].dor = s_q.dor_pend;
      s_d.dor_pend = 1'b0;
      s_d.pend_v = 1'b0;
      c = c + 2'h1;
    end

    case (s_q.rst)
      urp_pkg::RX_IDLE:
      begin
        if (s_q.sync ? (xck_rise && !i_serial_in_pin)
                     : (tick && s_q.rx_prev && !i_serial_in_pin))
        begin
          s_d.rst = s_q.sync ? urp_pkg::RX_DATA : urp_pkg::RX_START;
          s_d.rsamp = 5'h01;
          s_d.rbits = 4'h0;
          if (s_q.sync && c == 2'h2 && s_d.pend_v)
          begin
            s_d.dor_pend = 1'b1;
          end
        end
      end
      urp_pkg::RX_START:
      begin
        if (dec)
        begin
          if (bitv)
          begin
            s_d.rst = urp_pkg::RX_IDLE;
          end
          // A frame that moved up this cycle no longer waits
          else if (c == 2'h2 && s_d.pend_v)
          begin
            s_d.dor_pend = 1'b1;
          end
        end
        if (adv && s_d.rst == urp_pkg::RX_START)
        begin
          s_d.rst = urp_pkg::RX_DATA;
        end
      end
      urp_pkg::RX_DATA:
      begin
        if (dec)
        begin
          s_d.rsh = {bitv, s_q.rsh[8:1]};
        end
        if (adv)
        begin
          s_d.rbits = s_q.rbits + 4'h1;
          if (s_q.rbits == n - 4'h1)
          begin
            s_d.rst = s_q.pon ? urp_pkg::RX_PAR : urp_pkg::RX_STOP;
          end
        end
      end
      urp_pkg::RX_PAR:
      begin
        if (dec)
        begin
          s_d.rpar = bitv;
        end
        if (adv)
        begin
          s_d.rst = urp_pkg::RX_STOP;
        end
      end
      urp_pkg::RX_STOP:
      begin
        // Only the first stop is voted on; a second one looks idle
        if (dec)
        begin
          rdat = s_q.rsh >> (4'h9 - n);
          e.nine = (s_q.size == urp_pkg::SIZE_NINE) & rdat[8];
          e.data = rdat[7:0];
          e.fe = ~bitv;
          e.upe = s_q.pon & (par(rdat, s_q.podd) != s_q.rpar);
          s_d.rst = urp_pkg::RX_IDLE;
          if (c != 2'h2)
          begin
            e.dor = s_d.dor_pend;
            s_d.buff[p + c[0]] = e;
            s_d.dor_pend = 1'b0;
            c = c + 2'h1;
          end
          else if (!s_d.pend_v)
          begin
            s_d.pend = e;
            s_d.pend_v = 1'b1;
          end
        end
      end
      default:
      begin
        s_d.rst = urp_pkg::RX_IDLE;
      end
    endcase
    s_d.rd_ptr = p;
    s_d.cnt = c;

    // Receiver off: drop the frame in flight and all buffered data
    if (!s_q.rxen)
    begin
      s_d.rst = urp_pkg::RX_IDLE;
      s_d.rsamp = 5'h00;
      s_d.cnt = 2'h0;
      s_d.pend_v = 1'b0;
      s_d.dor_pend = 1'b0;
    end

    // Transmitter
    if (s_q.sync)
    begin
      tbit = xck_fall;
    end
    else if (tick)
    begin
      s_d.tsamp = s_q.tsamp + 5'h01;
      if (s_q.tsamp + 5'h01 == os_n)
      begin
        s_d.tsamp = 5'h00;
        tbit = 1'b1;
      end
    end
    if (s_q.tbusy && tbit)
    begin
      if (s_q.tleft == 4'h0)
      begin
        s_d.tbusy = 1'b0;
        s_d.txd = 1'b1;
      end
      else
      begin
        s_d.txd = s_q.tsh[0];
        s_d.tsh = {1'b1, s_q.tsh[12:1]};
        s_d.tleft = s_q.tleft - 4'h1;
      end
    end
    // Queued data is sent even after enable drops
    if (s_q.tbuf_v && !s_d.tbusy)
    begin
      s_d.tsh = txframe(s_q.tbuf, n, s_q.pon, s_q.podd) >> 1;
      s_d.txd = 1'b0;
      s_d.tleft = n + {3'h0, s_q.pon} + {3'h0, s_q.usbs} + 4'h1;
      s_d.tbusy = 1'b1;
      s_d.tbuf_v = 1'b0;
      s_d.tsamp = 5'h00;
    end
    s_d.toe = s_q.tx_enable_bit | s_d.tbusy | s_d.tbuf_v;
    s_d.take = s_q.rxen;
    s_d.irq = s_q.rxcie & (s_d.cnt != 2'h0);
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_q <= '0;
      s_q.baud <= urp_pkg::BAUD_RST;
      s_q.bcnt <= urp_pkg::BAUD_RST;
      s_q.size <= urp_pkg::SIZE_RST;
      s_q.rx_prev <= 1'b1;
      // Idle level of the transfer clock, so no false edge follows reset
      s_q.xck_prev <= 1'b1;
      s_q.rst <= urp_pkg::RX_IDLE;
      s_q.txd <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;
  assign o_serial_out_pin = s_q.txd;
  assign o_serial_out_pin_oe = s_q.toe;
  assign o_serial_in_take = s_q.take;
  assign o_rx_complete_irq = s_q.irq;
endmodule : urp_usart_rx
`default_nettype wire

// >>> test/urp_usart_rx_sva.sv
// Port checker for the serial receiver
`timescale 1ns/10ps
`default_nettype none
module urp_usart_rx_sva (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_arst_n,
  // Register port
  input wire urp_pkg::urp_bus_t i_bus,
  input wire logic [7:0] o_rdata,
  // Serial pins and receive complete interrupt
  input wire logic i_serial_in_pin,
  input wire logic i_transfer_clock_pin,
  input wire logic o_serial_out_pin,
  input wire logic o_serial_out_pin_oe,
  input wire logic o_serial_in_take,
  input wire logic o_rx_complete_irq
);
  default clocking dc @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);
  logic wc;
  logic cie_q;
  logic [7:0] fmt_q;
  assign wc = i_bus.wr && i_bus.addr == urp_pkg::ADR_CONTROL;
  // Shadows of the enables, since the checker cannot see inside
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      cie_q <= 1'b0;
      fmt_q <= 8'h06;
    end
    else
    begin
      if (wc)
        cie_q <= i_bus.wdata[urp_pkg::CB_RXCIE];
      if (i_bus.wr && i_bus.addr == urp_pkg::ADR_FORMAT)
        fmt_q <= i_bus.wdata;
    end
  end
  a_take_off: assert property (wc && !i_bus.wdata[urp_pkg::CB_RXEN] |-> ##[1:2] !o_serial_in_take)
    else $error("input pin kept after disable");
  a_flush_irq: assert property (wc && !i_bus.wdata[urp_pkg::CB_RXEN] |-> ##[1:3] !o_rx_complete_irq)
    else $error("buffer not flushed");
  a_irq_cause: assert property (o_rx_complete_irq |-> cie_q || $past(cie_q))
    else $error("irq without enable");
  a_rdata_idle: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("read data outside read");
  a_size_mask: assert property ($past(i_bus.rd && i_bus.addr == urp_pkg::ADR_DATA)
    |-> (o_rdata >> (5 + $past(fmt_q[2:1]))) == 8'h00)
    else $error("unused data bits set");
  a_par_off: assert property ($past(i_bus.rd && i_bus.addr == urp_pkg::ADR_STATUS
    && !fmt_q[urp_pkg::FC_PON]) |-> !o_rdata[urp_pkg::ST_UPE])
    else $error("parity error while off");
  a_oe_drain: assert property ($fell(o_serial_out_pin_oe) |-> $past(o_serial_out_pin))
    else $error("transmitter stopped mid frame");
  a_pin_idle: assert property (!o_serial_out_pin_oe |-> o_serial_out_pin)
    else $error("released pin not idle");
  c_irq: cover property ($rose(o_rx_complete_irq));
  c_oe: cover property ($fell(o_serial_out_pin_oe));
  c_fe: cover property ($past(i_bus.rd) && o_rdata[urp_pkg::ST_FE]);
endmodule : urp_usart_rx_sva
bind urp_usart_rx urp_usart_rx_sva urp_usart_rx_sva_i (
  .i_clock(i_clock), .i_arst_n(i_arst_n), .i_bus(i_bus), .o_rdata(o_rdata),
  .i_serial_in_pin(i_serial_in_pin), .i_transfer_clock_pin(i_transfer_clock_pin),
  .o_serial_out_pin(o_serial_out_pin), .o_serial_out_pin_oe(o_serial_out_pin_oe),
  .o_serial_in_take(o_serial_in_take), .o_rx_complete_irq(o_rx_complete_irq)
);
`default_nettype wire

// >>> test/urp_line_model.sv
// Remote serial station: frame sender and frame catcher
`timescale 1ns/10ps
`default_nettype none
module urp_line_model (
  // Clock
  input wire logic i_clock,
  // From the block
  input wire logic i_tx_line,
  // To the block
  output logic o_line,
  output logic o_xck
);
  initial
  begin
    o_line = 1'b1;
    o_xck = 1'b1;
  end
  // LSB first; y: sync, xck rises mid bit and stands high between frames
  // z: one-cycle flip at bit centre, which a three-sample vote must ride out
  task automatic send(input logic [8:0] d, input int n, input logic p, input logic o,
    input logic b, input logic s, input int bt, input logic y, input logic z);
    logic [11:0] f;
    int m;
    f = {2'b11, d, 1'b0};
    m = n + 2 + int'(p);
    if (p)
      f[n + 1] = ^(d & ((9'h001 << n) - 9'h001)) ^ o ^ b;
    f[m - 1] = s;
    @(posedge i_clock);
    for (int i = 0; i < m; i++)
    begin
      o_line <= f[i];
      o_xck <= !y;
      repeat (bt / 2) @(posedge i_clock);
      o_xck <= 1'b1;
      o_line <= f[i] ^ z;
      @(posedge i_clock);
      o_line <= f[i];
      repeat (bt - bt / 2 - 1) @(posedge i_clock);
    end
    o_line <= 1'b1;
  endtask : send
  task automatic pulse(input int c);
    @(posedge i_clock);
    o_line <= 1'b0;
    repeat (c) @(posedge i_clock);
    o_line <= 1'b1;
  endtask : pulse
  // Samples m bits of an outgoing frame at their centres
  task automatic catch(input int m, input int bt, output logic [11:0] f);
    int w;
    f = 12'h000;
    w = 0;
    while (i_tx_line && w < 4000)
    begin
      @(posedge i_clock);
      w++;
    end
    repeat (bt / 2) @(posedge i_clock);
    for (int i = 0; i < m; i++)
    begin
      f[i] = i_tx_line;
      if (i < m - 1)
        repeat (bt) @(posedge i_clock);
    end
  endtask : catch
endmodule : urp_line_model
`default_nettype wire

// >>> test/urp_usart_rx_tb_top.sv
// Self-checking bench for the serial receiver
`timescale 1ns/10ps
`default_nettype none
module urp_usart_rx_tb_top;
  logic i_clock;
  logic i_arst_n;
  urp_pkg::urp_bus_t bus;
  logic [7:0] rdata;
  logic line;
  logic xck;
  logic txd;
  logic oe;
  logic take;
  logic irq;
  int n_fail;
  int n_tests;
  logic [7:0] v;
  logic [8:0] d;
  logic [11:0] f;
  logic [11:0] g;
  logic [7:0] q [4];
  logic [2:0] sz;
  logic o;
  urp_usart_rx urp_usart_rx_i (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_bus(bus), .o_rdata(rdata),
    .i_serial_in_pin(line), .i_transfer_clock_pin(xck), .o_serial_out_pin(txd),
    .o_serial_out_pin_oe(oe), .o_serial_in_take(take), .o_rx_complete_irq(irq)
  );
  urp_line_model urp_line_model_i (
    .i_clock(i_clock), .i_tx_line(txd), .o_line(line), .o_xck(xck)
  );
  function automatic logic [7:0] masked(logic [8:0] x, int n);
    return x[7:0] & 8'(9'h1FF >> (9 - n));
  endfunction : masked
  function automatic logic par(logic [7:0] x, logic od);
    return ^x ^ od;
  endfunction : par
  task automatic check(input logic [11:0] s, input logic [11:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge i_clock);
    bus <= '{addr: a, wdata: w, wr: 1'b1, rd: 1'b0};
    @(posedge i_clock);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge i_clock);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clock);
    bus.rd <= 1'b0;
    #1 v = rdata;
    check(v, e);
  endtask : rc
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  // Whole run is near 4700 cycles
  initial
  begin
    repeat (20000) @(posedge i_clock);
    n_fail++;
    stop_test();
  end
  initial
  begin
    i_arst_n = 1'b0;
    bus = '0;
    n_fail = 0;
    n_tests = 0;
    void'($urandom(32'h222a));
    repeat (8) @(posedge i_clock);
    i_arst_n <= 1'b1;
    rc(3'h0, 8'h20);
    rc(3'h1, 8'h00);
    rc(3'h2, 8'h06);
    wr(3'h6, 8'hFF);
    rc(3'h6, 8'h00);
    $display("test reset done");
    wr(3'h1, 8'h90);
    for (int i = 0; i < 8; i++)
    begin
      d = 9'($urandom());
      o = 1'($urandom());
      wr(3'h2, {2'b00, i[1], i[0], i[2], 3'h6});
      urp_line_model_i.send(d, 8, i[1], i[0], i[2], !o, 16, 1'b0, 1'b0);
      // Status write of zeros must leave the stored flags alone
      wr(3'h0, 8'h00);
      rc(3'h0, {3'b101, o, 1'b0, i[1] & i[2], 2'b00});
      rc(3'h5, d[7:0]);
      rc(3'h0, 8'h20);
    end
    $display("test parity done");
    for (int k = 0; k < 5; k++)
    begin
      sz = (k == 4) ? 3'h7 : k[2:0];
      d = 9'($urandom());
      wr(3'h1, {5'b10010, sz[2], 2'b00});
      wr(3'h2, {5'b00000, sz[1:0], 1'b0});
      urp_line_model_i.send(d, (k == 4) ? 9 : k + 5, 1'b0, 1'b0, 1'b0, 1'b1, 16, 1'b0, 1'b0);
      rc(3'h1, {5'b10010, sz[2], (k == 4) & d[8], 1'b0});
      rc(3'h5, masked(d, (k == 4) ? 9 : k + 5));
    end
    $display("test sizes done");
    wr(3'h1, 8'h90);
    wr(3'h2, 8'h06);
    for (int i = 0; i < 4; i++)
    begin
      q[i] = 8'($urandom());
      urp_line_model_i.send({1'b0, q[i]}, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16, 1'b0, 1'b0);
    end
    check(irq, 1'b1);
    rc(3'h0, 8'hA0);
    rc(3'h5, q[0]);
    rc(3'h0, 8'hA0);
    rc(3'h5, q[1]);
    rc(3'h0, 8'hA8);
    rc(3'h5, q[2]);
    rc(3'h0, 8'h20);
    check(irq, 1'b0);
    $display("test overrun done");
    for (int i = 0; i < 2; i++)
      urp_line_model_i.send({1'b0, q[i]}, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16, 1'b0, 1'b0);
    // All-ones frame: a receiver that wrongly kept going would store it
    fork
      urp_line_model_i.send(9'h0FF, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16, 1'b0, 1'b0);
      begin
        repeat (40) @(posedge i_clock);
        wr(3'h1, 8'h80);
        repeat (3) @(posedge i_clock);
        check(take, 1'b0);
        check(irq, 1'b0);
        wr(3'h1, 8'h90);
      end
    join
    repeat (4) @(posedge i_clock);
    check(take, 1'b1);
    rc(3'h0, 8'h20);
    $display("test flush done");
    urp_line_model_i.pulse(4);
    repeat (300) @(posedge i_clock);
    rc(3'h0, 8'h20);
    urp_line_model_i.pulse(12);
    repeat (300) @(posedge i_clock);
    rc(3'h0, 8'hA0);
    rc(3'h5, 8'hFF);
    wr(3'h0, 8'h02);
    rc(3'h0, 8'h22);
    d = 9'($urandom());
    urp_line_model_i.send(d, 8, 1'b0, 1'b0, 1'b0, 1'b1, 8, 1'b0, 1'b1);
    rc(3'h5, d[7:0]);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h46);
    urp_line_model_i.send(d, 8, 1'b0, 1'b0, 1'b0, 1'b1, 16, 1'b1, 1'b0);
    rc(3'h5, d[7:0]);
    $display("test sampling done");
    o = 1'($urandom());
    // Two stop bits on the way out, so the second stop is seen too
    wr(3'h2, {3'b001, o, 4'hE});
    wr(3'h1, 8'h08);
    fork
      begin
        urp_line_model_i.catch(12, 16, f);
        urp_line_model_i.catch(12, 16, g);
      end
      begin
        wr(3'h5, q[0]);
        wr(3'h5, q[1]);
        wr(3'h1, 8'h00);
      end
    join
    check(f, {2'b11, par(q[0], o), q[0], 1'b0});
    check(g, {2'b11, par(q[1], o), q[1], 1'b0});
    repeat (40) @(posedge i_clock);
    check(oe, 1'b0);
    $display("test transmit done");
    stop_test();
  end
endmodule : urp_usart_rx_tb_top
`default_nettype wire
